/* inc/plb_pkg.sv */
// Constants, types and shared decode for the power-line buffer control registers.
// Assumes a byte-wide register port behind the host's I2C slave.
// Functional notes
// - Bit 7 of buffer status reads 1 only while both receive buffers hold data.
// - While both buffers are full, the next bulk data-out request is refused.
// - A received packet sets the pending flag, new-packet event and byte count.
// - The pending flag holds until the host writes 1, which frees a buffer.
// - A bulk data-out request arriving while pending is set is refused.
// - With chaining on, later bulk packets start automatically after command done.
// - Readback swap selects automatic buffer control or host readback of sent data.
// - Refuse-serial bit set refuses serial mode requests, otherwise they are acknowledged.
// - Refuse-sleep bit set refuses idle system requests, otherwise they are acknowledged.
// - Data packet retry count is field plus one; field resets to seven.
// - Pin-set argument: upper nibble pull enables, lower nibble output levels, pins 4..1.
// - Bulk request byte count is the argument plus one.
// - Serial mode argument: 0 off, 1 receive, 2 transmit, 3 loopback.
// - System request codes 0..7: seal, soft, hard, gauge, FIFO, free, idle, both.
// - System argument with upper six bits all ones: hard reset into serial mode.
// - The command trigger starts a command and clears once it is sent.
// - Received byte count reports bytes of the last request as field plus one.
package plb_pkg;
    localparam logic [7:0] ADDR_BUF_STATUS = 8'h36;
    localparam logic [7:0] ADDR_POLICY     = 8'h37;
    localparam logic [7:0] ADDR_CMD_ARG    = 8'h38;
    localparam int BIT_ALL_FULL   = 7;
    localparam int BIT_PENDING    = 6;
    localparam int BIT_AUTO_CHAIN = 0;
    localparam int BIT_SWAP       = 7;
    localparam int BIT_NO_SERIAL  = 5;
    localparam int BIT_NO_SLEEP   = 4;
    localparam int RETRY_MSB      = 2;
    localparam logic [2:0] RETRY_RESET = 3'h7;
    localparam logic [7:0] ARG_RESET   = 8'h00;
    localparam logic [2:0] SYS_IDLE    = 3'h6;
    localparam logic [5:0] SYS_SERIAL  = 6'h3F;

    typedef enum logic [1:0] {
        PLB_REQ_BULK   = 2'b00,
        PLB_REQ_SERIAL = 2'b01,
        PLB_REQ_SYSTEM = 2'b10,
        PLB_REQ_OTHER  = 2'b11
    } plb_req_t;

    typedef enum logic [1:0] {
        PLB_TX_IDLE      = 2'b00,
        PLB_TX_WAIT_SENT = 2'b01,
        PLB_TX_WAIT_DONE = 2'b10
    } plb_tx_state_t;

    // True for the plain idle-mode system request code.
    function automatic logic plb_is_idle(input logic [7:0] arg);
        plb_is_idle = (arg == {5'h00, SYS_IDLE});
    endfunction : plb_is_idle

    // Total automatic attempts for a retry field value.
    function automatic logic [3:0] plb_retry_total(input logic [2:0] f);
        plb_retry_total = {1'b0, f} + 4'h1;
    endfunction : plb_retry_total
endpackage : plb_pkg

/* rtl/plb_arg_decode.sv */
// Combinational decode of the channel-1 command argument.
// Assumes the caller registers every output it uses; sys_idle drives d_idle, which plb_regs never uses.
`timescale 1ns/100ps
module plb_arg_decode
    import plb_pkg::*;
(
    input  wire logic [7:0] arg,
    output logic      [3:0] pull_en,
    output logic      [3:0] out_level,
    output logic      [8:0] byte_total,
    output logic            ser_rx_on,
    output logic            ser_tx_on,
    output logic      [2:0] sys_code,
    output logic            sys_idle,
    output logic            sys_serial,
    output logic            rem_tx_sel,
    output logic            rem_rx_sel
);
    always_comb begin
        pull_en    = arg[7:4];
        out_level  = arg[3:0];
        byte_total = {1'b0, arg} + 9'h001;
        ser_rx_on  = arg[0];
        ser_tx_on  = arg[1];
        sys_code   = arg[2:0];
        sys_idle   = plb_is_idle(arg);
        sys_serial = (arg[7:2] == SYS_SERIAL);
        rem_tx_sel = arg[1];
        rem_rx_sel = arg[0];
    end
endmodule : plb_arg_decode

/* rtl/plb_regs.sv */
// Buffer status, request policy and argument registers of the power-line link.
// Assumes a byte register port from the host I2C slave and pulse events from the link engine.
`timescale 1ns/100ps
module plb_regs
    import plb_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       link_req_valid,
    input  wire plb_req_t   link_req_kind,
    input  wire logic [7:0] link_req_arg,
    output logic            reply_ack,
    output logic            reply_nack,
    input  wire logic       rx_packet_in,
    input  wire logic [6:0] rx_count_in,
    output logic            new_packet_event,
    output logic      [6:0] received_byte_count,
    output logic      [7:0] received_bytes_total,
    output logic            buffers_all_full,
    output logic            rx_packet_pending,
    input  wire logic       trigger_write,
    input  wire logic       cmd_is_bulk,
    input  wire logic       cmd_sent_in,
    input  wire logic       cmd_done_in,
    input  wire logic       pkt_nack_in,
    output logic            cmd_start,
    output logic            command_trigger,
    output logic            send_failed,
    output logic            readback_swap,
    output logic      [3:0] retry_total,
    output logic      [3:0] pin_pull_enable,
    output logic      [3:0] pin_output_level,
    output logic      [8:0] bulk_byte_total,
    output logic            serial_rx_on,
    output logic            serial_tx_on,
    output logic      [2:0] system_code,
    output logic            system_serial_reset,
    output logic            remote_serial_tx_sel,
    output logic            remote_serial_rx_sel
);
    logic [1:0]    buf_full_reg;
    logic          wr_sel_reg;
    logic          rd_sel_reg;
    logic          pending_reg;
    logic          auto_chain_reg;
    logic          swap_reg;
    logic          no_serial_reg;
    logic          no_sleep_reg;
    logic [2:0]    retry_lim_reg;
    logic [7:0]    arg_reg;
    logic [3:0]    retry_left_reg;
    plb_tx_state_t tx_state_reg;
    plb_tx_state_t tx_state_next;

    logic       wr_status;
    logic       host_clear;
    logic       all_full;
    logic       refuse;
    logic [7:0] rdata_next;
    logic [3:0] d_pull;
    logic [3:0] d_level;
    logic [8:0] d_bytes;
    logic       d_rx_on;
    logic       d_tx_on;
    logic [2:0] d_sys;
    logic       d_idle;
    logic       d_serial;
    logic       d_rtx;
    logic       d_rrx;

    assign wr_status  = reg_wr && (reg_addr == ADDR_BUF_STATUS);
    assign host_clear = wr_status && reg_wdata[BIT_PENDING];
    assign all_full   = &buf_full_reg;

    plb_arg_decode u_dec (
        .arg        (arg_reg),
        .pull_en    (d_pull),
        .out_level  (d_level),
        .byte_total (d_bytes),
        .ser_rx_on  (d_rx_on),
        .ser_tx_on  (d_tx_on),
        .sys_code   (d_sys),
        .sys_idle   (d_idle),
        .sys_serial (d_serial),
        .rem_tx_sel (d_rtx),
        .rem_rx_sel (d_rrx)
    );

    // Host-writable fields. Reserved bits are not stored, so they always read zero.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            auto_chain_reg <= 1'b0;
            swap_reg       <= 1'b0;
            no_serial_reg  <= 1'b0;
            no_sleep_reg   <= 1'b0;
            retry_lim_reg  <= RETRY_RESET;
            arg_reg        <= ARG_RESET;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == ADDR_BUF_STATUS) begin
                auto_chain_reg <= reg_wdata[BIT_AUTO_CHAIN];
            end
            if (reg_addr == ADDR_POLICY) begin
                swap_reg      <= reg_wdata[BIT_SWAP];
                no_serial_reg <= reg_wdata[BIT_NO_SERIAL];
                no_sleep_reg  <= reg_wdata[BIT_NO_SLEEP];
                retry_lim_reg <= reg_wdata[RETRY_MSB:0];
            end
            if (reg_addr == ADDR_CMD_ARG) begin
                arg_reg <= reg_wdata;
            end
        end
    end

    // Two receive buffers filled and freed in turn. A host clear frees the oldest.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            buf_full_reg <= 2'h0;
            wr_sel_reg   <= 1'b0;
            rd_sel_reg   <= 1'b0;
        end else if (clk_en) begin
            if (host_clear && buf_full_reg[rd_sel_reg]) begin
                buf_full_reg[rd_sel_reg] <= 1'b0;
                rd_sel_reg               <= ~rd_sel_reg;
            end
            if (rx_packet_in && !buf_full_reg[wr_sel_reg]) begin
                buf_full_reg[wr_sel_reg] <= 1'b1;
                wr_sel_reg               <= ~wr_sel_reg;
            end
        end
    end

    // A packet arriving in the same cycle as a host clear keeps the flag set.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pending_reg <= 1'b0;
        end else if (clk_en) begin
            if (rx_packet_in) begin
                pending_reg <= 1'b1;
            end else if (host_clear) begin
                pending_reg <= 1'b0;
            end
        end
    end

    // Receive side events and the byte count shown to the host.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            new_packet_event     <= 1'b0;
            received_byte_count  <= 7'h00;
            received_bytes_total <= 8'h00;
        end else if (clk_en) begin
            new_packet_event <= rx_packet_in;
            if (rx_packet_in) begin
                received_byte_count  <= rx_count_in;
                received_bytes_total <= {1'b0, rx_count_in} + 8'h01;
            end
        end
    end

    always_comb begin
        case (link_req_kind)
            PLB_REQ_BULK:   refuse = all_full || pending_reg;
            PLB_REQ_SERIAL: refuse = no_serial_reg;
            PLB_REQ_SYSTEM: refuse = no_sleep_reg && plb_is_idle(link_req_arg);
            default:        refuse = 1'b0;
        endcase
    end

    // Every request from across the link seen while clk_en is high gets exactly one answer, one cycle later.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reply_ack  <= 1'b0;
            reply_nack <= 1'b0;
        end else if (clk_en) begin
            reply_ack  <= link_req_valid && !refuse;
            reply_nack <= link_req_valid && refuse;
        end
    end

    always_comb begin
        tx_state_next = tx_state_reg;
        case (tx_state_reg)
            PLB_TX_IDLE: begin
                if (trigger_write) begin
                    tx_state_next = PLB_TX_WAIT_SENT;
                end
            end
            PLB_TX_WAIT_SENT: begin
                if (cmd_sent_in) begin
                    tx_state_next = PLB_TX_WAIT_DONE;
                end
            end
            PLB_TX_WAIT_DONE: begin
                if (pkt_nack_in) begin
                    tx_state_next = (retry_left_reg != 4'h0) ? PLB_TX_WAIT_SENT : PLB_TX_IDLE;
                end else if (cmd_done_in) begin
                    if (auto_chain_reg && cmd_is_bulk) begin
                        tx_state_next = PLB_TX_WAIT_SENT;
                    end else begin
                        tx_state_next = PLB_TX_IDLE;
                    end
                end
            end
            default: tx_state_next = PLB_TX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_state_reg <= PLB_TX_IDLE;
        end else if (clk_en) begin
            tx_state_reg <= tx_state_next;
        end
    end

    // Start pulses, the trigger flag and the packet retry budget.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cmd_start       <= 1'b0;
            command_trigger <= 1'b0;
            send_failed     <= 1'b0;
            retry_left_reg  <= 4'h0;
        end else if (clk_en) begin
            cmd_start   <= 1'b0;
            send_failed <= 1'b0;
            case (tx_state_reg)
                PLB_TX_IDLE: begin
                    if (trigger_write) begin
                        cmd_start       <= 1'b1;
                        command_trigger <= 1'b1;
                        retry_left_reg  <= plb_retry_total(retry_lim_reg);
                    end
                end
                PLB_TX_WAIT_SENT: begin
                    if (cmd_sent_in) begin
                        command_trigger <= 1'b0;
                    end
                end
                PLB_TX_WAIT_DONE: begin
                    if (pkt_nack_in) begin
                        if (retry_left_reg != 4'h0) begin
                            cmd_start       <= 1'b1;
                            command_trigger <= 1'b1;
                            retry_left_reg  <= retry_left_reg - 4'h1;
                        end else begin
                            send_failed <= 1'b1;
                        end
                    end else if (cmd_done_in && auto_chain_reg && cmd_is_bulk) begin
                        cmd_start       <= 1'b1;
                        command_trigger <= 1'b1;
                        retry_left_reg  <= plb_retry_total(retry_lim_reg);
                    end
                end
                default: cmd_start <= 1'b0;
            endcase
        end
    end

    always_comb begin
        case (reg_addr)
            ADDR_BUF_STATUS: rdata_next = {all_full, pending_reg, 5'h00, auto_chain_reg};
            ADDR_POLICY:     rdata_next = {swap_reg, 1'b0, no_serial_reg, no_sleep_reg,
                                           1'b0, retry_lim_reg};
            ADDR_CMD_ARG:    rdata_next = arg_reg;
            default:         rdata_next = 8'h00;
        endcase
    end

    // Read data and mirrored flags, all from flip-flops.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata         <= 8'h00;
            buffers_all_full  <= 1'b0;
            rx_packet_pending <= 1'b0;
            readback_swap     <= 1'b0;
            retry_total       <= 4'h0;
        end else if (clk_en) begin
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
            buffers_all_full  <= all_full;
            rx_packet_pending <= pending_reg;
            readback_swap     <= swap_reg;
            retry_total       <= plb_retry_total(retry_lim_reg);
        end
    end

    // Decoded argument fields for the link command builder.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pin_pull_enable      <= 4'h0;
            pin_output_level     <= 4'h0;
            bulk_byte_total      <= 9'h000;
            serial_rx_on         <= 1'b0;
            serial_tx_on         <= 1'b0;
            system_code          <= 3'h0;
            system_serial_reset  <= 1'b0;
            remote_serial_tx_sel <= 1'b0;
            remote_serial_rx_sel <= 1'b0;
        end else if (clk_en) begin
            pin_pull_enable      <= d_pull;
            pin_output_level     <= d_level;
            bulk_byte_total      <= d_bytes;
            serial_rx_on         <= d_rx_on;
            serial_tx_on         <= d_tx_on;
            system_code          <= d_sys;
            system_serial_reset  <= d_serial;
            remote_serial_tx_sel <= d_rtx;
            remote_serial_rx_sel <= d_rrx;
        end
    end

    property p_full_nack;
        @(posedge sys_clk) disable iff (reset)
        clk_en && link_req_valid && link_req_kind == PLB_REQ_BULK && all_full
        |=> reply_nack && !reply_ack;
    endproperty
    a_full_nack: assert property (p_full_nack) else $error("bulk request accepted while full");

    property p_pending_nack;
        @(posedge sys_clk) disable iff (reset)
        clk_en && link_req_valid && link_req_kind == PLB_REQ_BULK && pending_reg
        |=> reply_nack && !reply_ack;
    endproperty
    a_pending_nack: assert property (p_pending_nack) else $error("bulk accepted while pending");

    property p_rx_sets;
        @(posedge sys_clk) disable iff (reset)
        clk_en && rx_packet_in |=> pending_reg && new_packet_event
        && received_byte_count == $past(rx_count_in);
    endproperty
    a_rx_sets: assert property (p_rx_sets) else $error("receive did not set pending");

    property p_w1c;
        @(posedge sys_clk) disable iff (reset)
        clk_en && host_clear && !rx_packet_in |=> !pending_reg;
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear pending");

    property p_w0_keeps;
        @(posedge sys_clk) disable iff (reset)
        clk_en && wr_status && !reg_wdata[BIT_PENDING] && pending_reg |=> pending_reg;
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("write zero changed pending");

    property p_full_read;
        @(posedge sys_clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == ADDR_BUF_STATUS
        |=> reg_rdata[BIT_ALL_FULL] == &$past(buf_full_reg);
    endproperty
    a_full_read: assert property (p_full_read) else $error("full bit read wrong");

    property p_serial_refuse;
        @(posedge sys_clk) disable iff (reset)
        clk_en && link_req_valid && link_req_kind == PLB_REQ_SERIAL
        |=> reply_nack == $past(no_serial_reg) && reply_ack != $past(no_serial_reg);
    endproperty
    a_serial_refuse: assert property (p_serial_refuse) else $error("serial answer wrong");

    property p_idle_refuse;
        @(posedge sys_clk) disable iff (reset)
        clk_en && link_req_valid && link_req_kind == PLB_REQ_SYSTEM
        && link_req_arg == 8'h06 |=> reply_nack == $past(no_sleep_reg);
    endproperty
    a_idle_refuse: assert property (p_idle_refuse) else $error("idle answer wrong");

    property p_chain;
        @(posedge sys_clk) disable iff (reset)
        clk_en && tx_state_reg == PLB_TX_WAIT_DONE && cmd_done_in && !pkt_nack_in
        && auto_chain_reg && cmd_is_bulk |=> cmd_start && tx_state_reg == PLB_TX_WAIT_SENT;
    endproperty
    a_chain: assert property (p_chain) else $error("chained packet not started");

    property p_trig_clear;
        @(posedge sys_clk) disable iff (reset)
        clk_en && tx_state_reg == PLB_TX_WAIT_SENT && cmd_sent_in |=> !command_trigger;
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared");

    property p_retry_load;
        @(posedge sys_clk) disable iff (reset)
        clk_en && tx_state_reg == PLB_TX_IDLE && trigger_write
        |=> retry_left_reg == {1'b0, $past(retry_lim_reg)} + 4'h1;
    endproperty
    a_retry_load: assert property (p_retry_load) else $error("retry budget wrong");

    property p_bytes;
        @(posedge sys_clk) disable iff (reset)
        clk_en |=> bulk_byte_total == {1'b0, $past(arg_reg)} + 9'h001;
    endproperty
    a_bytes: assert property (p_bytes) else $error("byte total wrong");
endmodule : plb_regs

/* verif/plb_slave.sv */
// Far-side slave model: link requests, received packets and command events.
// Assumes its tasks are called just after a rising edge of sys_clk.
`timescale 1ns/100ps
module plb_slave
    import plb_pkg::*;
(
    input  wire logic       sys_clk,
    output logic            link_req_valid,
    output plb_req_t        link_req_kind,
    output logic      [7:0] link_req_arg,
    output logic            rx_packet_in,
    output logic      [6:0] rx_count_in,
    output logic            cmd_sent_in,
    output logic            cmd_done_in,
    output logic            pkt_nack_in
);
    // Released data lines show the inverse of their last value, so stale data never matches.
    initial begin
        {link_req_valid, rx_packet_in, cmd_sent_in, cmd_done_in, pkt_nack_in} = 5'h00;
        link_req_kind = PLB_REQ_OTHER;
        {link_req_arg, rx_count_in} = 15'h0000;
    end
    // Each task lets one idle edge pass, so back-to-back calls never redrive a strobe at once.
    task automatic request(input plb_req_t k, input logic [7:0] a);
        link_req_kind = k;
        link_req_arg = a;
        link_req_valid = 1'b1;
        @(posedge sys_clk);
        #1 link_req_valid = 1'b0;
        link_req_arg = ~a;
        @(posedge sys_clk);
        #1;
    endtask : request
    task automatic packet(input logic [6:0] c);
        rx_count_in = c;
        rx_packet_in = 1'b1;
        @(posedge sys_clk);
        #1 rx_packet_in = 1'b0;
        rx_count_in = ~c;
        @(posedge sys_clk);
        #1;
    endtask : packet
    task automatic event_pulse(input logic [2:0] e);
        {pkt_nack_in, cmd_done_in, cmd_sent_in} = e;
        @(posedge sys_clk);
        #1 {pkt_nack_in, cmd_done_in, cmd_sent_in} = 3'h0;
        @(posedge sys_clk);
        #1;
    endtask : event_pulse
endmodule : plb_slave

/* verif/tb.sv */
// Self-checking bench for the power-line buffer control registers.
// Assumes the slave model drives the link side; all stimulus lands 1 ns after an edge.
`timescale 1ns/100ps
module tb
    import plb_pkg::*;
;
    logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, trigger_write = 0, cmd_is_bulk = 0;
    logic clk_en = 1;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, received_bytes_total, v, a;
    logic link_req_valid, rx_packet_in, cmd_sent_in, cmd_done_in, pkt_nack_in, rd_q = 0;
    logic [6:0] rx_count_in, received_byte_count;
    logic [7:0] link_req_arg;
    plb_req_t link_req_kind;
    logic reply_ack, reply_nack, new_packet_event, buffers_all_full, rx_packet_pending;
    logic cmd_start, command_trigger, send_failed, readback_swap, serial_rx_on, serial_tx_on;
    logic system_serial_reset, remote_serial_tx_sel, remote_serial_rx_sel;
    logic [3:0] retry_total, pin_pull_enable, pin_output_level;
    logic [8:0] bulk_byte_total;
    logic [2:0] system_code;
    logic [7:0] rq[$];
    logic [1:0] aq[$];
    int fail_count = 0, n_compared = 0, cyc = 0, ns, nf, ne;
    plb_regs plb_regs_i (.sys_clk, .reset, .clk_en, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .link_req_valid, .link_req_kind, .link_req_arg, .reply_ack,
        .reply_nack, .rx_packet_in, .rx_count_in, .new_packet_event, .received_byte_count,
        .received_bytes_total, .buffers_all_full, .rx_packet_pending, .trigger_write,
        .cmd_is_bulk, .cmd_sent_in, .cmd_done_in, .pkt_nack_in, .cmd_start, .command_trigger,
        .send_failed, .readback_swap, .retry_total, .pin_pull_enable, .pin_output_level,
        .bulk_byte_total, .serial_rx_on, .serial_tx_on, .system_code, .system_serial_reset,
        .remote_serial_tx_sel, .remote_serial_rx_sel);
    plb_slave plb_slave_i (.sys_clk, .link_req_valid, .link_req_kind, .link_req_arg,
        .rx_packet_in, .rx_count_in, .cmd_sent_in, .cmd_done_in, .pkt_nack_in);
    always #10 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [8:0] s, e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic final_report;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] ad, d);
        {reg_addr, reg_wdata, reg_wr} = {ad, d, 1'b1};
        @(posedge sys_clk);
        #1 {reg_wr, reg_wdata} = {1'b0, ~d};
        @(posedge sys_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] ad, e);
        rq.push_back(e);
        {reg_addr, reg_rd} = {ad, 1'b1};
        @(posedge sys_clk);
        #1 reg_rd = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : rd
    task automatic lreq(input plb_req_t k, input logic [7:0] ar, input logic nk);
        aq.push_back({~nk, nk});
        plb_slave_i.request(k, ar);
    endtask : lreq
    // Counts event pulses over four cycles, so pulse latency need not be pinned here.
    task automatic win;
        {ns, nf, ne} = '0;
        repeat (4) begin
            #2 ns += cmd_start;
            nf += send_failed;
            ne += new_packet_event;
            @(posedge sys_clk);
        end
        #1;
    endtask : win
    always @(posedge sys_clk) begin
        #2 if (rd_q) chk("rdata", reg_rdata, rq.pop_front());
        if (reply_ack | reply_nack) chk("reply", {reply_ack, reply_nack}, aq.pop_front());
        rd_q = reg_rd;
        if (++cyc == 3000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        void'($urandom(32'hBDADC89A));
        repeat (6) @(posedge sys_clk);
        #1 reset = 1'b0;
        rd(ADDR_BUF_STATUS, 8'h00);
        rd(ADDR_POLICY, 8'h07);
        rd(ADDR_CMD_ARG, 8'h00);
        rd(8'h39, 8'h00);
        chk("retry", retry_total, 4'h8);
        for (int i = 0; i < 4; i++) begin
            v = $urandom();
            wr(ADDR_POLICY, v);
            rd(ADDR_POLICY, v & 8'hB7);
            chk("retry", retry_total, {1'b0, v[2:0]} + 4'h1);
            chk("swap", readback_swap, v[7]);
        end
        for (int i = 0; i < 6; i++) begin
            a = (i < 4) ? i[7:0] : ((i == 4) ? 8'hFE : $urandom());
            wr(ADDR_CMD_ARG, a);
            rd(ADDR_CMD_ARG, a);
            chk("pull", pin_pull_enable, a[7:4]);
            chk("level", pin_output_level, a[3:0]);
            chk("bytes", bulk_byte_total, {1'b0, a} + 9'h001);
            if (a < 4) chk("serial", {serial_rx_on, serial_tx_on}, {a[0], a[1]});
            chk("sys", system_code, a[2:0]);
            chk("sersys", system_serial_reset, a[7:2] == 6'h3F);
            if (a[7:2] == 6'h3F)
                chk("sel", {remote_serial_tx_sel, remote_serial_rx_sel}, a[1:0]);
        end
        // A write while the clock enable is low must not land.
        clk_en = 1'b0;
        wr(ADDR_CMD_ARG, ~a);
        clk_en = 1'b1;
        rd(ADDR_CMD_ARG, a);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_POLICY, {2'h0, i[1], i[0], 4'h7});
            lreq(PLB_REQ_SERIAL, {6'h00, i[1:0]}, i[1]);
            lreq(PLB_REQ_SYSTEM, 8'h06, i[0]);
            lreq(PLB_REQ_SYSTEM, 8'h02, 1'b0);
        end
        wr(ADDR_POLICY, 8'h07);
        lreq(PLB_REQ_BULK, 8'h10, 1'b0);
        a = $urandom();
        fork
            plb_slave_i.packet(a[6:0]);
            win;
        join
        chk("newpkt", ne, 1);
        chk("count", received_bytes_total, {1'b0, a[6:0]} + 8'h01);
        chk("rxcnt", received_byte_count, a[6:0]);
        chk("pendpin", rx_packet_pending, 1'b1);
        rd(ADDR_BUF_STATUS, 8'h40);
        lreq(PLB_REQ_BULK, 8'h00, 1'b1);
        plb_slave_i.packet(7'h7F);
        rd(ADDR_BUF_STATUS, 8'hC0);
        chk("full", buffers_all_full, 1'b1);
        lreq(PLB_REQ_BULK, 8'h00, 1'b1);
        wr(ADDR_BUF_STATUS, 8'h00);
        rd(ADDR_BUF_STATUS, 8'hC0);
        wr(ADDR_BUF_STATUS, 8'h40);
        wr(ADDR_BUF_STATUS, 8'h40);
        rd(ADDR_BUF_STATUS, 8'h00);
        lreq(PLB_REQ_BULK, 8'h00, 1'b0);
        wr(ADDR_BUF_STATUS, 8'h01);
        rd(ADDR_BUF_STATUS, 8'h01);
        wr(ADDR_POLICY, 8'h00);
        {cmd_is_bulk, trigger_write} = 2'b11;
        @(posedge sys_clk);
        #1 trigger_write = 1'b0;
        win;
        chk("start", ns, 1);
        chk("trig", command_trigger, 1'b1);
        plb_slave_i.event_pulse(3'h1);
        win;
        chk("trig", command_trigger, 1'b0);
        wr(ADDR_CMD_ARG, 8'h0F);
        chk("bytes", bulk_byte_total, 9'h010);
        fork
            plb_slave_i.event_pulse(3'h2);
            win;
        join
        chk("chain", {ns[0], command_trigger}, 2'b11);
        for (int i = 0; i < 2; i++) begin
            plb_slave_i.event_pulse(3'h1);
            fork
                plb_slave_i.event_pulse(3'h4);
                win;
            join
            chk("retry", {ns[1:0], nf[1:0]}, (i == 0) ? 4'h4 : 4'h1);
        end
        chk("queues", rq.size() + aq.size(), 0);
        final_report();
    end
endmodule : tb
